// File: design/thsc_params.svh
`ifndef THSC_PARAMS_SVH
`define THSC_PARAMS_SVH

// register word indices (byte address = index * 4)
`define THSC_IDX_CTRL      6'h00
`define THSC_IDX_PER       6'h01
`define THSC_IDX_AMP       6'h02
`define THSC_IDX_OFFSET    6'h03
`define THSC_IDX_CNT       6'h04
`define THSC_IDX_CMP_BASE  4'h2
`define THSC_IDX_BUF_BASE  4'h3

// control register field positions
`define THSC_CTRL_ENABLE   0
`define THSC_CTRL_HR_LO    1
`define THSC_CTRL_HR_HI    2
`define THSC_CTRL_AM_LO    3
`define THSC_CTRL_AM_HI    4
`define THSC_CTRL_AMPLITUDE_APPLY_ENABLE    5
`define THSC_CTRL_SCALE    6
`define THSC_CTRL_W        7

// reset values
`define THSC_RST_CTRL      7'h00
`define THSC_RST_PER       16'hffff
`define THSC_RST_WORD      16'h0000

// arithmetic limits and thresholds
`define THSC_SAT_MAX       16'hffff
`define THSC_FRAC_FULL     16'h8000
`define THSC_FRAC_QUARTER  16'h4000
`define THSC_FRAC_SHIFT    15

// fast clock runs at 4x the peripheral rate
`define THSC_CLK_MHZ       100
`define THSC_PER_DIV       4
`define THSC_PER_LAST      2'h3

`endif

// File: design/thsc_pkg.sv
package thsc_pkg;

	// resolution select: off, 4x, 8x, spare code treated as off
	typedef enum logic [1:0] {
		THSC_HR_OFF,
		THSC_HR_4X,
		THSC_HR_8X,
		THSC_HR_SPARE
	} thsc_hires_e;

	// range anchor mode for amplitude and offset
	typedef enum logic [1:0] {
		THSC_AM_CENTER,
		THSC_AM_BOTTOM,
		THSC_AM_TOP,
		THSC_AM_BOTH_ENDS
	} thsc_anchor_e;

	typedef logic [15:0] thsc_word_t;

endpackage : thsc_pkg

// File: design/thsc_top.sv
// Contract
// - 4x counts fast rising edges only; 8x counts both edges of that clock
// - resolution select gives 0, 2 or 3 low bits and steps 1, 4, 8
// - overflow and match use upper bits; low bits handled at fast rate
// - only one pulse edge moves; compare low bits set its sub-period position
// - period ignores low bits, so frequency follows the scaled forms
// - counter reads return zero in extension-owned low bits
// - events depend on upper counter bits only
// - hi-res never emits pulse under one peripheral cycle; compare below four silent
// - scaled writes treat compare, buffer, amplitude data as UQ1.15
// - scaled amplitude high-byte write stores fraction times period; reads give product
// - amplitude product above 0xffff saturates to 0xffff
// - cycle after amplitude write, offset recomputed from range anchor mode
// - offset clamped at zero when amplitude exceeds period
// - scaled compare high-byte write stores fraction times amplitude plus offset
// - amplitude off: fraction times period; bottom no offset; center/top add offset
// - both-ends mode picks bottom, period, product or product plus offset
// - compare product above 0xffff saturates to 0xffff
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "thsc_params.svh"
module thsc_top
	import thsc_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// wishbone classic slave
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_wdat,
	output      logic [31:0] wb_rdat,
	output      logic        wb_ack,
	// waveform outputs, first and second half of each fast cycle
	output      logic [3:0]  wave_first,
	output      logic [3:0]  wave_second,
	// event pulses, one fast cycle wide, raised on a peripheral tick
	output      logic        ovf_event,
	output      logic [3:0]  cmp_event
);

	// low-bit mask of the counter for a resolution select
	function automatic thsc_word_t lsb_mask(input logic [1:0] hr);
		case (hr)
			THSC_HR_4X: lsb_mask = 16'hfffc;
			THSC_HR_8X: lsb_mask = 16'hfff8;
			default:    lsb_mask = 16'hffff;
		endcase
	endfunction : lsb_mask

	// saturate an 18-bit result to 16 bits
	function automatic thsc_word_t sat16(input logic [17:0] v);
		sat16 = (|v[17:16]) ? `THSC_SAT_MAX : v[15:0];
	endfunction : sat16

	// UQ1.15 fraction times a 16-bit value, 17 integer bits kept
	function automatic logic [16:0] frac_mul(input thsc_word_t f, input thsc_word_t x);
		logic [31:0] p;
		p = 32'(f) * 32'(x);
		frac_mul = p[31:`THSC_FRAC_SHIFT];
	endfunction : frac_mul

	logic [`THSC_CTRL_W-1:0] ctrl_r;
	thsc_word_t              per_r;
	thsc_word_t              amp_r;
	thsc_word_t              offset_r;
	thsc_word_t              cnt_r;
	thsc_word_t              cmp_r [0:3];
	thsc_word_t              cmpbuf_r [0:3];
	logic [3:0]              bufv_r;
	logic [7:0]              lo_hold_r;
	logic                    offset_pend_r;
	logic                    ack_r;
	logic [31:0]             rdat_r;
	logic [1:0]              ph_r;
	logic [3:0]              wf_r;
	logic [3:0]              ws_r;
	logic                    ovf_r;
	logic [3:0]              cev_r;

	// control fields
	wire         run_en  = ctrl_r[`THSC_CTRL_ENABLE];
	wire [1:0]   hr      = ctrl_r[`THSC_CTRL_HR_HI:`THSC_CTRL_HR_LO];
	wire [1:0]   anchor  = ctrl_r[`THSC_CTRL_AM_HI:`THSC_CTRL_AM_LO];
	wire         amp_use = ctrl_r[`THSC_CTRL_AMPLITUDE_APPLY_ENABLE];
	wire         scale   = ctrl_r[`THSC_CTRL_SCALE];
	wire         hr_on   = (hr == THSC_HR_4X) || (hr == THSC_HR_8X);

	// bus decode; one access per request, ack blocks back-to-back reuse
	wire         req     = wb_cyc && wb_stb && !ack_r;
	wire         wr      = req && wb_we;
	wire [5:0]   idx     = wb_adr[7:2];
	wire         is_ctrl = (idx == `THSC_IDX_CTRL);
	wire         is_per  = (idx == `THSC_IDX_PER);
	wire         is_amp  = (idx == `THSC_IDX_AMP);
	wire         is_off  = (idx == `THSC_IDX_OFFSET);
	wire         is_cnt  = (idx == `THSC_IDX_CNT);
	wire         is_cmp  = (idx[5:2] == `THSC_IDX_CMP_BASE);
	wire         is_buf  = (idx[5:2] == `THSC_IDX_BUF_BASE);
	wire [1:0]   ch      = idx[1:0];
	wire         wr_hi   = wr && wb_sel[1];
	wire         wr_lo   = wr && wb_sel[0] && !wb_sel[1];

	// scaled registers take the low byte from the holding latch on a high-only write
	wire thsc_word_t wdat16 = {wb_wdat[15:8], wb_sel[0] ? wb_wdat[7:0] : lo_hold_r};

	// low-bit view of counter and period
	wire thsc_word_t mask   = lsb_mask(hr);
	wire thsc_word_t cnt_m  = cnt_r & mask;
	wire thsc_word_t per_m  = per_r & mask;
	wire thsc_word_t step   = thsc_word_t'(~mask + 16'h0001);
	wire             per_tk = (ph_r == `THSC_PER_LAST);
	wire             tick   = run_en && per_tk;
	wire             wrap   = (cnt_m >= per_m);
	wire thsc_word_t cnt_nxt = wrap ? `THSC_RST_WORD : thsc_word_t'(cnt_m + step);

	// amplitude scaling: fraction times the current period
	wire [16:0]      amp_prod = frac_mul(wdat16, per_r);
	wire thsc_word_t amp_nxt  = scale ? sat16({1'b0, amp_prod}) : wdat16;

	// offset from anchor mode, never below zero
	wire             amp_big  = (amp_r > per_r);
	wire thsc_word_t per_diff = amp_big ? `THSC_RST_WORD : thsc_word_t'(per_r - amp_r);
	wire thsc_word_t off_nxt  = (anchor == THSC_AM_BOTTOM) ? `THSC_RST_WORD :
	                            (anchor == THSC_AM_CENTER) ? {1'b0, per_diff[15:1]} :
	                            per_diff;

	// compare scaling, done within the write cycle
	wire [16:0]      cp_per   = frac_mul(wdat16, per_r);
	wire [16:0]      cp_amp   = frac_mul(wdat16, amp_r);
	wire thsc_word_t cv_per   = sat16({1'b0, cp_per});
	wire thsc_word_t cv_amp   = sat16({1'b0, cp_amp});
	wire thsc_word_t cv_off   = sat16(18'(cp_amp) + 18'(offset_r));
	wire thsc_word_t cv_both  = (wdat16 == `THSC_RST_WORD) ? `THSC_RST_WORD :
	                            (wdat16 >= `THSC_FRAC_FULL) ? per_r :
	                            (wdat16 >= `THSC_FRAC_QUARTER) ? cv_amp : cv_off;
	wire thsc_word_t cv_anch  = (anchor == THSC_AM_BOTTOM) ? cv_amp :
	                            (anchor == THSC_AM_BOTH_ENDS) ? cv_both : cv_off;
	wire thsc_word_t cmp_nxt  = !scale ? wdat16 : (amp_use ? cv_anch : cv_per);

	// read selection; unmapped words read as zero
	wire thsc_word_t rd16 = is_per ? per_r :
	                        is_amp ? amp_r :
	                        is_off ? offset_r :
	                        is_cnt ? cnt_m :
	                        is_cmp ? cmp_r[ch] :
	                        is_buf ? cmpbuf_r[ch] : `THSC_RST_WORD;
	wire [31:0]      rd_nxt = is_ctrl ? {25'h0000000, ctrl_r} : {16'h0000, rd16};

	// wishbone answer one cycle after the request, dropped the cycle after
	always_ff @(posedge clock) begin
		if (srst) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h00000000;
		end else begin
			ack_r  <= req;
			rdat_r <= (req && !wb_we) ? rd_nxt : rdat_r;
		end
	end

	// control, period and low-byte holding latch
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_r    <= `THSC_RST_CTRL;
			per_r     <= `THSC_RST_PER;
			lo_hold_r <= 8'h00;
		end else begin
			if (wr && is_ctrl && wb_sel[0])
				ctrl_r <= wb_wdat[`THSC_CTRL_W-1:0];
			if (wr && is_per && wb_sel[0])
				per_r[7:0] <= wb_wdat[7:0];
			if (wr && is_per && wb_sel[1])
				per_r[15:8] <= wb_wdat[15:8];
			if (wr_lo && (is_amp || is_cmp || is_buf))
				lo_hold_r <= wb_wdat[7:0];
		end
	end

	// amplitude on the high-byte write, offset one cycle later
	always_ff @(posedge clock) begin
		if (srst) begin
			amp_r         <= `THSC_RST_WORD;
			offset_r      <= `THSC_RST_WORD;
			offset_pend_r <= 1'b0;
		end else begin
			offset_pend_r <= wr_hi && is_amp;
			if (wr_hi && is_amp)
				amp_r <= amp_nxt;
			if (offset_pend_r)
				offset_r <= off_nxt;
		end
	end

	// peripheral tick divider; the phase doubles as the fast sub-slot index
	always_ff @(posedge clock) begin
		if (srst)
			ph_r <= 2'h0;
		else
			ph_r <= ph_r + 2'h1;
	end

	// counter advances on upper bits only, by the resolution step
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_r <= `THSC_RST_WORD;
			ovf_r <= 1'b0;
		end else begin
			ovf_r <= tick && wrap;
			if (tick)
				cnt_r <= cnt_nxt;
		end
	end

	// per channel: compare, buffer, waveform and match event
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			wire thsc_word_t cmp_m  = cmp_r[gi] & mask;
			wire             match  = (cnt_m == cmp_m);
			// fraction in eighths of a peripheral period
			wire [2:0]       frac8  = (hr == THSC_HR_8X) ? cmp_r[gi][2:0] :
			                          (hr == THSC_HR_4X) ? {cmp_r[gi][1:0], 1'b0} : 3'h0;
			wire [2:0]       pos_a  = {ph_r, 1'b0};
			wire [2:0]       pos_b  = {ph_r, 1'b1};
			// sub-period pulses that would start and end inside one tick are dropped
			wire             silent = !run_en || (hr_on && (cmp_m == `THSC_RST_WORD));
			wire             full   = (cnt_m < cmp_m);
			wire             lvl_a  = !silent && (full || (match && (pos_a < frac8)));
			wire             lvl_b  = !silent && (full || (match && (pos_b < frac8)));
			wire             wr_c   = wr_hi && is_cmp && (ch == 2'(gi));
			wire             wr_b   = wr_hi && is_buf && (ch == 2'(gi));
			wire             xfer   = tick && wrap && bufv_r[gi];

			// a fresh write beats the buffer transfer; a buffer write keeps it valid
			always_ff @(posedge clock) begin
				if (srst) begin
					cmp_r[gi]    <= `THSC_RST_WORD;
					cmpbuf_r[gi] <= `THSC_RST_WORD;
					bufv_r[gi]   <= 1'b0;
				end else begin
					if (wr_c)
						cmp_r[gi] <= cmp_nxt;
					else if (xfer)
						cmp_r[gi] <= cmpbuf_r[gi];
					if (wr_b)
						cmpbuf_r[gi] <= cmp_nxt;
					bufv_r[gi] <= wr_b || (bufv_r[gi] && !xfer);
				end
			end

			// outputs are flopped so half-slot samples stay glitch free
			always_ff @(posedge clock) begin
				if (srst) begin
					wf_r[gi]  <= 1'b0;
					ws_r[gi]  <= 1'b0;
					cev_r[gi] <= 1'b0;
				end else begin
					wf_r[gi]  <= lvl_a;
					ws_r[gi]  <= lvl_b;
					cev_r[gi] <= tick && match;
				end
			end
		end
	endgenerate

	// output drive
	assign wb_ack      = ack_r;
	assign wb_rdat     = rdat_r;
	assign wave_first  = wf_r;
	assign wave_second = ws_r;
	assign ovf_event   = ovf_r;
	assign cmp_event   = cev_r;

	// counter reads in 4x never show the owned low bits
	a_cnt_read_low: assert property (@(posedge clock) disable iff (srst)
		(req && !wb_we && is_cnt && (hr == THSC_HR_4X)) |=> (wb_ack && (wb_rdat[1:0] == 2'h0)))
		else $error("counter read shows low bits in 4x");

	// 4x step is four per peripheral tick
	a_step_four: assert property (@(posedge clock) disable iff (srst)
		(tick && !wrap && (hr == THSC_HR_4X) && !wr) |=> (cnt_r == 16'($past(cnt_m) + 16'h0004)))
		else $error("4x counter step is not four");

	// overflow fires exactly as the counter returns to bottom
	a_ovf_bottom: assert property (@(posedge clock) disable iff (srst)
		ovf_event |-> ((cnt_r == 16'h0000) && $past(tick)))
		else $error("overflow without return to bottom");

	// amplitude product saturates
	a_amp_saturate: assert property (@(posedge clock) disable iff (srst)
		(wr_hi && is_amp && scale && amp_prod[16]) |=> (amp_r == 16'hffff))
		else $error("amplitude did not saturate");

	// bottom anchor gives zero offset one cycle after the amplitude write
	a_offset_bottom: assert property (@(posedge clock) disable iff (srst)
		(wr_hi && is_amp && (anchor == THSC_AM_BOTTOM)) |=> ##1 (offset_r == 16'h0000))
		else $error("bottom anchor offset not zero");

	// offset clamps at zero when amplitude exceeds period
	a_offset_clamp: assert property (@(posedge clock) disable iff (srst)
		(offset_pend_r && amp_big) |=> (offset_r == 16'h0000))
		else $error("offset went negative");

	// unscaled compare write stores the data as given
	a_plain_store: assert property (@(posedge clock) disable iff (srst)
		(wr_hi && is_cmp && (ch == 2'h0) && !scale) |=> (cmp_r[0] == $past(wdat16)))
		else $error("unscaled compare altered");

	// both-ends anchor with a full fraction stores the period
	a_both_full: assert property (@(posedge clock) disable iff (srst)
		(wr_hi && is_cmp && (ch == 2'h0) && scale && amp_use && (anchor == THSC_AM_BOTH_ENDS) &&
		 (wdat16 >= 16'h8000)) |=> (cmp_r[0] == $past(per_r)))
		else $error("both-ends full fraction not period");

	// compare below four in hi-res gives no output
	a_tiny_silent: assert property (@(posedge clock) disable iff (srst)
		(hr_on && ((cmp_r[0] & mask) == 16'h0000)) |=> (!wave_first[0] && !wave_second[0]))
		else $error("sub-tick pulse emitted");

	// 8x: a one-eighth fraction is high in the first half slot only
	a_eighth_edge: assert property (@(posedge clock) disable iff (srst)
		(run_en && (hr == THSC_HR_8X) && (ph_r == 2'h0) && (cnt_m == (cmp_r[0] & mask)) &&
		 ((cmp_r[0] & mask) != 16'h0000) && (cmp_r[0][2:0] == 3'h1)) |=> (wave_first[0] && !wave_second[0]))
		else $error("8x half-edge resolution wrong");

	// 8x step is eight per peripheral tick
	a_step_eight: assert property (@(posedge clock) disable iff (srst)
		(tick && !wrap && (hr == THSC_HR_8X) && !wr) |=> (cnt_r == 16'($past(cnt_m) + 16'h0008)))
		else $error("8x counter step is not eight");

	// off and the spare code step by one, so the fine bits never leak into the count
	a_step_one: assert property (@(posedge clock) disable iff (srst)
		(tick && !wrap && !hr_on && !wr) |=> (cnt_r == 16'($past(cnt_m) + 16'h0001)))
		else $error("coarse counter step is not one");

	// a match event only follows a tick whose upper bits matched
	a_match_event: assert property (@(posedge clock) disable iff (srst)
		cmp_event[0] |-> ($past(tick) && $past(g_ch[0].match)))
		else $error("match event without upper-bit match");

endmodule : thsc_top

// File: bench/thsc_top_tb_top.sv
`timescale 1ns/1ps
module thsc_top_tb_top
	import thsc_pkg::*;
;
	// dut ports
	logic        clock;
	logic        srst;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic [3:0]  wave_first;
	logic [3:0]  wave_second;
	logic        ovf_event;
	logic [3:0]  cmp_event;
	// bookkeeping: each note is {expected, mask}
	int          fail_count;
	int          checks_done;
	logic [63:0] note_q[$];
	logic [63:0] note;
	thsc_word_t  p, af, a, o, f;
	logic [7:0]  adr;
	logic [2:0]  jj;
	localparam logic [7:0] A_CTRL = 8'h00, A_PER = 8'h04, A_AMP = 8'h08, A_OFF = 8'h0c, A_CNT = 8'h10;
	localparam logic [31:0] M32 = 32'hffffffff;
	localparam thsc_word_t FR [6] = '{16'h0000, 16'h3fff, 16'h4000, 16'h8000, 16'hffff, 16'h2000};
	localparam logic [31:0] MSK [3] = '{32'hffff0000, 32'hffff0003, 32'hffff0007};
	localparam int GAP [3] = '{132, 36, 20};
	localparam int HF [3] = '{76, 19, 10};
	localparam int HS [3] = '{76, 19, 9};

	thsc_top i_thsc_top (.clock(clock), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack),
		.wave_first(wave_first), .wave_second(wave_second), .ovf_event(ovf_event), .cmp_event(cmp_event));

	// 100 mhz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	// classic cycle: hold everything until ack is sampled, then idle one cycle
	task automatic bus(input logic we_i, input logic [7:0] ad, input thsc_word_t d);
		int n;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we_i;
		wb_adr <= ad;
		wb_sel <= 4'h3;
		wb_wdat <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic wr(input logic [7:0] ad, input thsc_word_t d);
		bus(1'b1, ad, d);
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
		note_q.push_back({e, m});
		bus(1'b0, ad, 16'h0000);
	endtask : rd

	// read monitor: oldest note against the returned data
	always @(posedge clock) begin
		if (wb_ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0) begin
			if (note_q.size() == 0) begin
				fail_count++;
			end else begin
				note = note_q.pop_front();
				check(wb_rdat & note[31:0], note[63:32] & note[31:0]);
			end
		end
	end

	// reference arithmetic, product truncated after the 15 fraction bits
	function automatic thsc_word_t scl(input thsc_word_t fr, input thsc_word_t x);
		logic [31:0] pr;
		pr = ({16'h0000, fr} * {16'h0000, x}) >> 15;
		return (pr > 32'h0000ffff) ? 16'hffff : pr[15:0];
	endfunction : scl

	function automatic thsc_word_t sat_add(input thsc_word_t x, input thsc_word_t y);
		logic [16:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[16] ? 16'hffff : s[15:0];
	endfunction : sat_add

	function automatic thsc_word_t off_of(input logic [1:0] md, input thsc_word_t pe, input thsc_word_t am);
		thsc_word_t d;
		d = (am > pe) ? 16'h0000 : pe - am;
		if (md == 2'h1) return 16'h0000;
		return (md == 2'h0) ? d >> 1 : d;
	endfunction : off_of

	function automatic thsc_word_t cmp_of(input logic [1:0] md, input logic ae, input thsc_word_t fr,
		input thsc_word_t pe, input thsc_word_t am, input thsc_word_t of);
		if (!ae) return scl(fr, pe);
		if (md == 2'h1) return scl(fr, am);
		if (md == 2'h3 && fr == 16'h0000) return 16'h0000;
		if (md == 2'h3 && fr >= 16'h8000) return pe;
		if (md == 2'h3 && fr >= 16'h4000) return scl(fr, am);
		return sat_add(scl(fr, am), of);
	endfunction : cmp_of

	function automatic thsc_word_t ctl(input logic en, input logic [1:0] hr, input logic [1:0] md,
		input logic ae, input logic sc);
		return {9'h000, sc, ae, md, hr, en};
	endfunction : ctl

	// cycles between two pulses of overflow (0) or compare channel 0 (1)
	task automatic gap(input int which, input int exp);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (((which == 0) ? ovf_event : cmp_event[0]) !== 1'b1 && n < 400);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (((which == 0) ? ovf_event : cmp_event[0]) !== 1'b1 && n < 400);
		@(posedge clock);
		check(n, exp);
	endtask : gap

	// high samples of channel 0 over one whole period
	task automatic hi_count(input int cyc, input int e1, input int e2);
		int c1, c2;
		c1 = 0;
		c2 = 0;
		repeat (cyc) begin
			@(negedge clock);
			c1 += (wave_first[0] === 1'b1);
			c2 += (wave_second[0] === 1'b1);
		end
		@(posedge clock);
		check(c1, e1);
		check(c2, e2);
	endtask : hi_count

	// watchdog, far beyond the expected run of a few thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		end_sim();
	end

	initial begin
		srst = 1'b1;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
		fail_count = 0;
		checks_done = 0;
		void'($urandom(32'h2d2c812c));
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		// reset contents and an unmapped word
		rd(A_CTRL, 32'h0, M32);
		rd(A_PER, 32'h0000ffff, M32);
		rd(A_OFF, 32'h0, M32);
		rd(8'h44, 32'h0, M32);
		// unscaled writes on every channel
		for (int ch = 0; ch < 4; ch++) begin
			f = 16'($urandom);
			wr(A_AMP, f);
			rd(A_AMP, {16'h0, f}, M32);
			wr(8'h20 | 8'(ch << 2), f ^ 16'h5a5a);
			rd(8'h20 | 8'(ch << 2), {16'h0, f ^ 16'h5a5a}, M32);
			wr(8'h30 | 8'(ch << 2), ~f);
			rd(8'h30 | 8'(ch << 2), {16'h0, ~f}, M32);
		end
		// scaled writes over every anchor mode, with and without amplitude
		for (int md = 0; md < 4; md++) for (int ae = 0; ae < 2; ae++) for (int k = 0; k < 3; k++) begin
			p = (k == 2) ? 16'hffff : 16'($urandom_range(32'hffff, 32'h0100));
			af = (k == 0) ? 16'($urandom_range(32'h7fff, 32'h0)) : 16'hffff;
			wr(A_CTRL, ctl(1'b0, 2'h0, 2'(md), 1'(ae), 1'b1));
			wr(A_PER, p);
			wr(A_AMP, af);
			a = scl(af, p);
			o = off_of(2'(md), p, a);
			rd(A_AMP, {16'h0, a}, M32);
			rd(A_OFF, {16'h0, o}, M32);
			for (int j = 0; j < 6; j++) begin
				jj = 3'(j);
				adr = {2'b00, 1'b1, jj[0], jj[2:1], 2'b00};
				f = (j == 5) ? 16'($urandom) : FR[j];
				wr(adr, f);
				rd(adr, {16'h0, cmp_of(2'(md), 1'(ae), f, p, a, o)}, M32);
			end
		end
		// high resolution: period with clear low bits; buffer 0 is still valid from the scaled
		// writes, so it is loaded with 0x13 and carries it into compare 0 at the first wrap
		wr(A_CTRL, ctl(1'b0, 2'h0, 2'h0, 1'b0, 1'b0));
		wr(8'h20, 16'h0005);
		wr(8'h30, 16'h0013);
		wr(A_PER, 16'h0020);
		for (int hr = 0; hr < 3; hr++) begin
			wr(A_CTRL, ctl(1'b1, 2'(hr), 2'h0, 1'b0, 1'b0));
			repeat (3) rd(A_CNT, 32'h0, MSK[hr]);
			gap(0, GAP[hr]);
			gap(1, GAP[hr]);
			hi_count(GAP[hr], HF[hr], HS[hr]);
		end
		rd(8'h20, 32'h00000013, M32);
		// compare below four is silent in both fine modes
		wr(8'h20, 16'h0003);
		for (int hr = 1; hr < 3; hr++) begin
			wr(A_CTRL, ctl(1'b1, 2'(hr), 2'h0, 1'b0, 1'b0));
			gap(0, GAP[hr]);
			hi_count(GAP[hr], 0, 0);
		end
		// 8x with a one-eighth fraction: only the first half slot of the match tick is high
		wr(8'h20, 16'h0011);
		wr(A_CTRL, ctl(1'b1, 2'h2, 2'h0, 1'b0, 1'b0));
		gap(1, GAP[2]);
		hi_count(GAP[2], 9, 8);
		// spare resolution code counts like off
		wr(A_CTRL, ctl(1'b1, 2'h3, 2'h0, 1'b0, 1'b0));
		gap(0, GAP[0]);
		end_sim();
	end

endmodule : thsc_top_tb_top
